// [rtl/frtsc_regs.svh]
// register offsets, field positions, reset values and timing counts of the reference block
`ifndef FRTSC_REGS_SVH
`define FRTSC_REGS_SVH

`define FRTSC_ADDR_W            4
`define FRTSC_OFS_CTRL          4'h0
`define FRTSC_OFS_MUX           4'h1
`define FRTSC_OFS_STATUS        4'h2

`define FRTSC_BIT_READY         7
`define FRTSC_BIT_REF_EN        6
`define FRTSC_BIT_TS_EN         5
`define FRTSC_BIT_TS_RNG        4
`define FRTSC_CTRL_RESET        8'h00
`define FRTSC_CHAN_TEMP         4'he
`define FRTSC_CHAN_REF          4'hf

// settling of the reference before ready rises, in ns, and its cycle count
`define FRTSC_SETTLE_NS         1000
`define FRTSC_CLK_NS            8
`define FRTSC_SETTLE_CYC        ((`FRTSC_SETTLE_NS + `FRTSC_CLK_NS - 1) / `FRTSC_CLK_NS)

`endif

// [rtl/frtsc_pkg.sv]
// types of the reference and temperature sensor control block
package frtsc_pkg;
  typedef logic [1:0] frtsc_gain_type;   // 00 off, 01 x1, 10 x2, 11 x4
  typedef logic [3:0] frtsc_chan_type;
  typedef enum logic [1:0] {
    FRTSC_REF_OFF,
    FRTSC_REF_SETTLE,
    FRTSC_REF_READY
  } frtsc_ref_state_type;
endpackage

// [rtl/frtsc_settle.sv]
// settling timer: ready rises a fixed time after the reference is switched on
`timescale 1ns/10ps
`default_nettype none
`include "frtsc_regs.svh"
module frtsc_settle (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control
  input  wire logic enable,
  // status
  output logic      ready
);
  import frtsc_pkg::*;

  localparam int unsigned SETTLE_CYC = `FRTSC_SETTLE_CYC;

  frtsc_ref_state_type state_q;
  logic [15:0]         cnt_q;

  // count settling cycles while enabled, drop at once when disabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= FRTSC_REF_OFF;
      cnt_q   <= 16'h0000;
    end else if (!enable) begin
      state_q <= FRTSC_REF_OFF;
      cnt_q   <= 16'h0000;
    end else begin
      unique case (state_q)
        FRTSC_REF_OFF: begin
          state_q <= FRTSC_REF_SETTLE;
          cnt_q   <= 16'h0001;
        end
        FRTSC_REF_SETTLE: begin
          if (cnt_q >= 16'(SETTLE_CYC)) begin
            state_q <= FRTSC_REF_READY;
          end
          cnt_q <= cnt_q + 16'h0001;
        end
        FRTSC_REF_READY: begin
          state_q <= FRTSC_REF_READY;
        end
        default: begin
          state_q <= FRTSC_REF_OFF;
        end
      endcase
    end
  end

  // gated by the enable so the flag drops in the same cycle the reference is switched off
  assign ready = enable && (state_q == FRTSC_REF_READY);
endmodule
`default_nettype wire

// [rtl/frtsc_top.sv]
// fixed reference and temperature indicator control with its register port
// What this block does
// - bit 7 of the control register is a read-only flag that is 1 when the reference is usable.
// - on standard-voltage variants the ready flag always reads 1 whatever the enable.
// - bit 6 is a read/write reference enable that resets to 0.
// - bit 5 is a read/write temperature indicator enable that resets to 0.
// - bit 4 selects the indicator range, 0 the four-junction drop and 1 the two, reset 0.
// - bits 1-0 select the reference level: off, x1, x2 or x4, reset 00.
// - the indicator output is routed to a converter input with no external pin.
// - the reference is selectable as a converter input under register control; this block takes the choice from the conv_channel_select input.
// - channel code 1110 chooses the indicator and 1111 the reference.
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "frtsc_regs.svh"
module frtsc_top #(
  parameter bit STD_VOLTAGE = 1'b0      // 1 for standard-voltage variants
) (
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    arst_n,
  // register port
  input  wire logic [3:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [7:0]                   reg_rdata,
  // converter input selector
  input  wire frtsc_pkg::frtsc_chan_type conv_channel_select,
  // analog controls
  output logic                         reference_enable,
  output logic                         temp_sensor_enable,
  output logic                         temp_sensor_range,
  output frtsc_pkg::frtsc_gain_type    converter_reference_gain,
  output logic                         mux_temp_sel,
  output logic                         mux_ref_sel
);
  import frtsc_pkg::*;

  localparam logic [7:0] CTRL_RESET = `FRTSC_CTRL_RESET;

  logic [1:0]     rst_sync_q;
  logic           rst_n;
  logic           ref_en_q;
  logic           ts_en_q;
  logic           ts_rng_q;
  frtsc_gain_type gain_q;
  logic           settled;
  logic           ready_flag;
  logic [7:0]     ctrl_view;
  logic [7:0]     rdata_d;

  // reset release through two flip-flops
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // writable control fields; bits 7 and 3-2 are not stored
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_en_q <= CTRL_RESET[`FRTSC_BIT_REF_EN];
      ts_en_q  <= CTRL_RESET[`FRTSC_BIT_TS_EN];
      ts_rng_q <= CTRL_RESET[`FRTSC_BIT_TS_RNG];
      gain_q   <= CTRL_RESET[1:0];
    end else if (reg_wr && reg_addr == `FRTSC_OFS_CTRL) begin
      ref_en_q <= reg_wdata[`FRTSC_BIT_REF_EN];
      ts_en_q  <= reg_wdata[`FRTSC_BIT_TS_EN];
      ts_rng_q <= reg_wdata[`FRTSC_BIT_TS_RNG];
      gain_q   <= reg_wdata[1:0];
    end
  end

  // settling of the reference
  frtsc_settle u_settle (
    .clk    (core_clk),
    .rst_n  (rst_n),
    .enable (ref_en_q),
    .ready  (settled)
  );

  assign ready_flag = STD_VOLTAGE ? 1'b1 : settled;
  assign ctrl_view  = {ready_flag, ref_en_q, ts_en_q, ts_rng_q, 2'h0, gain_q};

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = 8'h00;
    unique case (reg_addr)
      `FRTSC_OFS_CTRL:   rdata_d = ctrl_view;
      `FRTSC_OFS_MUX:    rdata_d = {4'h0, conv_channel_select};
      `FRTSC_OFS_STATUS: rdata_d = {6'h00, mux_ref_sel, mux_temp_sel};
      default:           rdata_d = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // registered analog controls and internal input routing
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reference_enable         <= 1'b0;
      temp_sensor_enable       <= 1'b0;
      temp_sensor_range        <= 1'b0;
      converter_reference_gain <= 2'h0;
      mux_temp_sel             <= 1'b0;
      mux_ref_sel              <= 1'b0;
    end else begin
      reference_enable         <= ref_en_q;
      temp_sensor_enable       <= ts_en_q;
      temp_sensor_range        <= ts_rng_q;
      converter_reference_gain <= gain_q;
      mux_temp_sel <= conv_channel_select == `FRTSC_CHAN_TEMP;
      mux_ref_sel  <= conv_channel_select == `FRTSC_CHAN_REF;
    end
  end

  // assertions
  property p_ready_std;
    @(posedge core_clk) disable iff (!rst_n) STD_VOLTAGE |-> ctrl_view[7];
  endproperty
  a_ready_std: assert property (p_ready_std) else $error("ready low on standard part");

  property p_ready_needs_en;
    @(posedge core_clk) disable iff (!rst_n) (!STD_VOLTAGE && !ref_en_q) |-> !ctrl_view[7];
  endproperty
  a_ready_needs_en: assert property (p_ready_needs_en) else $error("ready while disabled");

  property p_ref_en_wr;
    @(posedge core_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == `FRTSC_OFS_CTRL) |=> ##1 reference_enable == $past(reg_wdata[6], 2);
  endproperty
  a_ref_en_wr: assert property (p_ref_en_wr) else $error("reference enable not written");

  property p_ts_en_wr;
    @(posedge core_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == `FRTSC_OFS_CTRL) |=> ##1 temp_sensor_enable == $past(reg_wdata[5], 2);
  endproperty
  a_ts_en_wr: assert property (p_ts_en_wr) else $error("sensor enable not written");

  property p_rng_wr;
    @(posedge core_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == `FRTSC_OFS_CTRL) |=> ##1 temp_sensor_range == $past(reg_wdata[4], 2);
  endproperty
  a_rng_wr: assert property (p_rng_wr) else $error("range not written");

  property p_gain_wr;
    @(posedge core_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == `FRTSC_OFS_CTRL)
        |=> ##1 converter_reference_gain == $past(reg_wdata[1:0], 2);
  endproperty
  a_gain_wr: assert property (p_gain_wr) else $error("gain not written");

  property p_resv_zero;
    @(posedge core_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == `FRTSC_OFS_CTRL) |=> reg_rdata[3:2] == 2'h0;
  endproperty
  a_resv_zero: assert property (p_resv_zero) else $error("reserved bits nonzero");

  property p_mux_temp;
    @(posedge core_clk) disable iff (!rst_n)
      mux_temp_sel == ($past(conv_channel_select) == `FRTSC_CHAN_TEMP);
  endproperty
  a_mux_temp: assert property (p_mux_temp) else $error("indicator route wrong");

  property p_mux_ref;
    @(posedge core_clk) disable iff (!rst_n)
      mux_ref_sel == ($past(conv_channel_select) == `FRTSC_CHAN_REF);
  endproperty
  a_mux_ref: assert property (p_mux_ref) else $error("reference route wrong");

  c_ready_rise: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(ready_flag));
  c_temp_sel: cover property (@(posedge core_clk) disable iff (!rst_n) mux_temp_sel);
  c_gain4: cover property (@(posedge core_clk) disable iff (!rst_n) gain_q == 2'h3);
endmodule
`default_nettype wire

// [verif/test_frtsc_top.sv]
// self-checking bench of the reference and temperature indicator control block
`timescale 1ns/10ps
`default_nettype none
`include "frtsc_regs.svh"
module test_frtsc_top;
  import frtsc_pkg::*;
  logic                 core_clk = 1'b0;
  logic                 arst_n   = 1'b0;
  logic [3:0]           reg_addr = 4'h0;
  logic [7:0]           reg_wdata = 8'h00;
  logic                 reg_wr   = 1'b0;
  logic                 reg_rd   = 1'b0;
  logic [7:0]           reg_rdata, std_rdata, got;
  frtsc_chan_type       chan     = 4'h0;
  logic                 ref_en, ts_en, ts_rng, m_temp, m_ref;
  frtsc_gain_type       gain;
  int                   num_errors = 0;
  int                   checks = 0;
  int                   cycles = 0;
  logic [7:0]           wd;
  // clock and hang guard
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      num_errors++;
      wrap_up();
    end
  end
  frtsc_top frtsc_top_inst (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .conv_channel_select(chan), .reference_enable(ref_en), .temp_sensor_enable(ts_en),
    .temp_sensor_range(ts_rng), .converter_reference_gain(gain), .mux_temp_sel(m_temp),
    .mux_ref_sel(m_ref));
  // standard-voltage variant shares the register port
  frtsc_top #(.STD_VOLTAGE(1'b1)) std_inst (.core_clk(core_clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(std_rdata), .conv_channel_select(chan), .reference_enable(),
    .temp_sensor_enable(), .temp_sensor_range(), .converter_reference_gain(),
    .mux_temp_sel(), .mux_ref_sel());
  // expected control word, reserved bits cleared
  function automatic logic [7:0] exp_ctrl(input logic [7:0] w, input logic rdy);
    return {rdy, w[6:4], 2'b00, w[1:0]};
  endfunction
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
    if (a == `FRTSC_OFS_CTRL) chk8({7'h00, std_rdata[7]}, 8'h01);
  endtask
  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(63));
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    // reset values
    rd(`FRTSC_OFS_CTRL, got);
    chk8(got, `FRTSC_CTRL_RESET);
    // random control words, every gain code, reserved bits set
    for (int i = 0; i < 16; i++) begin
      wd = 8'($urandom);
      wd[1:0] = i[1:0];
      if (i == 3) wd = 8'hff;
      wr(`FRTSC_OFS_CTRL, wd);
      settle();
      chk8({ref_en, ts_en, ts_rng, 3'h0, gain}, {wd[6:4], 3'h0, wd[1:0]});
      rd(`FRTSC_OFS_CTRL, got);
      chk8(got & 8'h7f, exp_ctrl(wd, 1'b0));
      wr(4'h5, ~wd);
      rd(4'h5, got);
      chk8(got, 8'h00);
      rd(`FRTSC_OFS_CTRL, got);
      chk8(got & 8'h7f, exp_ctrl(wd, 1'b0));
    end
    // ready follows reference enable after settling
    wr(`FRTSC_OFS_CTRL, 8'h00);
    settle();
    wr(`FRTSC_OFS_CTRL, 8'h41);
    rd(`FRTSC_OFS_CTRL, got);
    chk8(got, exp_ctrl(8'h41, 1'b0));
    repeat (`FRTSC_SETTLE_CYC + 8) @(posedge core_clk);
    rd(`FRTSC_OFS_CTRL, got);
    chk8(got, exp_ctrl(8'h41, 1'b1));
    wr(`FRTSC_OFS_CTRL, 8'h01);
    settle();
    rd(`FRTSC_OFS_CTRL, got);
    chk8(got, exp_ctrl(8'h01, 1'b0));
    // every channel code against the internal routes
    for (int c = 0; c < 16; c++) begin
      @(posedge core_clk);
      chan <= c[3:0];
      settle();
      if (c == 14) begin
        repeat (2000) @(posedge core_clk);
        #1;
      end
      chk8({6'h00, m_ref, m_temp}, {6'h00, c == 15, c == 14});
      rd(`FRTSC_OFS_STATUS, got);
      chk8(got, {6'h00, c == 15, c == 14});
      rd(`FRTSC_OFS_MUX, got);
      chk8(got, {4'h0, c[3:0]});
    end
    wrap_up();
  end
endmodule
`default_nettype wire
